/* glut_pkg.sv */
// Package: register map, field layout and reset values of the gamma table loader
package glut_pkg;
    localparam int GLUT_AW = 11;
    localparam int GLUT_DW = 32;
    // Printed offsets are not all multiples of four: byte address = 4 * index
    localparam logic [11:0] GLUT_OVL_INDEX_IDX = 12'h400;
    localparam logic [11:0] GLUT_OVL_DATA_IDX = 12'h402;
    localparam logic [11:0] GLUT_PNL_INDEX_IDX = 12'h500;
    localparam logic [11:0] GLUT_PNL_DATA_IDX = 12'h502;
    localparam logic [11:0] GLUT_CTRL_IDX = 12'h600;
    localparam logic [11:0] GLUT_STAT_IDX = 12'h601;
    // Control register fields
    localparam int GLUT_CTRL_OVL_EN_BIT = 2;
    localparam int GLUT_CTRL_PORT_LSB = 10;
    localparam int GLUT_CTRL_BYPASS_BIT = 5;
    localparam int GLUT_CTRL_ACT_LSB = 13;
    localparam logic [2:0] GLUT_PORT_ALL_OFF = 3'h0;
    localparam logic [2:0] GLUT_ACT_INACTIVE = 3'h0;
    localparam logic [15:0] GLUT_REG_RESET = 16'h0000;
    localparam logic [7:0] GLUT_INDEX_LAST = 8'hFF;
    localparam logic [7:0] GLUT_INDEX_FIRST = 8'h00;
    localparam int GLUT_ENTRIES = 256;
    localparam int GLUT_RD_LATENCY = 1;

    typedef enum logic [1:0]
    {
        GLUT_IDLE = 2'b00,
        GLUT_WAIT = 2'b01,
        GLUT_DONE = 2'b10
    } glut_state_t;
endpackage

/* glut_mem_if.sv */
// Interface: write/read port between the loader and a gamma table memory
`timescale 1ns/1ps
interface glut_mem_if;
    logic we;
    logic [7:0] waddr;
    logic [23:0] wdata;
    logic [7:0] raddr;
    logic [23:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* glut_table_mem.sv */
// Module: one 256-entry RGB gamma table memory with registered read data
`timescale 1ns/1ps
module glut_table_mem #(
    parameter int DEPTH = 256
) (
    input wire logic mclk_i,      // Register clock
    glut_mem_if.mem port          // Write and read port
);
    import glut_pkg::*;

    logic [23:0] mem_q [DEPTH];
    logic [23:0] rdata_r;

    always_ff @(posedge mclk_i)
    begin
        if (port.we)
            mem_q[port.waddr] <= port.wdata;
        rdata_r <= mem_q[port.raddr];
    end

    assign port.rdata = rdata_r;
endmodule // glut_table_mem

/* glut_loader.sv */
// Module: gamma table loader with Avalon-MM register slave
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
// What this block does
// - overlay table 256 entries, 8-bit index register
// - panel table 256 entries, 8-bit index register
// - overlay index advances per entry, wraps FFh
// - panel index advances per entry, wraps FFh
// - overlay entry: green/red write, then blue
// - panel entry: green/red write, then blue
// - data port register resets to zero
module glut_loader (
    input wire logic mclk_i,                           // 100 MHz register clock
    input wire logic rst_n_i,                          // Synchronous reset, active low
    input wire logic [glut_pkg::GLUT_AW-1:0] avs_address_i, // Word address
    input wire logic avs_read_i,                       // Read request
    input wire logic avs_write_i,                      // Write request
    input wire logic [glut_pkg::GLUT_DW-1:0] avs_writedata_i, // Write data
    input wire logic [3:0] avs_byteenable_i,           // Byte enables
    output logic [glut_pkg::GLUT_DW-1:0] avs_readdata_o, // Read data
    output logic avs_waitrequest_o,                    // Stall
    output logic [23:0] ovl_entry_o,                   // Overlay table entry at probe index
    output logic [23:0] pnl_entry_o                    // Panel table entry at probe index
);
    import glut_pkg::*;

    // ------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------
    logic [7:0] ovl_idx_r, ovl_idx_nxt;
    logic [7:0] pnl_idx_r, pnl_idx_nxt;
    logic [15:0] ovl_data_r, pnl_data_r;
    logic ovl_half_r, pnl_half_r;
    logic [7:0] ovl_gr_r, ovl_rd_r, pnl_gr_r, pnl_rd_r;
    logic [15:0] ctrl_r;
    logic [7:0] probe_r;
    logic [31:0] rdata_r;
    logic [23:0] ovl_entry_r, pnl_entry_r;
    glut_state_t state_r, state_nxt;
    glut_mem_if ovl_if ();
    glut_mem_if pnl_if ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Index step with wrap from the last entry back to the first
    function automatic logic [7:0] next_index(input logic [7:0] idx);
        next_index = (idx == GLUT_INDEX_LAST) ? GLUT_INDEX_FIRST : idx + 8'h01;
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [11:0] word_idx = {1'b0, avs_address_i};
    // A write lands only at the edge where the master sees waitrequest low
    wire xfer_done = (state_r == GLUT_DONE);
    wire wr_go = avs_write_i && xfer_done;
    wire lo_en = avs_byteenable_i[0];
    wire hi_en = avs_byteenable_i[1];
    wire hit_ovl_idx = word_idx == GLUT_OVL_INDEX_IDX;
    wire hit_ovl_dat = word_idx == GLUT_OVL_DATA_IDX;
    wire hit_pnl_idx = word_idx == GLUT_PNL_INDEX_IDX;
    wire hit_pnl_dat = word_idx == GLUT_PNL_DATA_IDX;
    wire hit_ctrl = word_idx == GLUT_CTRL_IDX;
    wire hit_stat = word_idx == GLUT_STAT_IDX;
    wire [15:0] wd16 = {hi_en ? avs_writedata_i[15:8] : 8'h00, lo_en ? avs_writedata_i[7:0] : 8'h00};
    wire ovl_open = !ctrl_r[GLUT_CTRL_OVL_EN_BIT]
        || (ctrl_r[GLUT_CTRL_PORT_LSB+:3] == GLUT_PORT_ALL_OFF);
    wire pnl_open = ctrl_r[GLUT_CTRL_BYPASS_BIT]
        || (ctrl_r[GLUT_CTRL_ACT_LSB+:3] == GLUT_ACT_INACTIVE);
    wire ovl_dwr = wr_go && hit_ovl_dat && ovl_open;
    wire pnl_dwr = wr_go && hit_pnl_dat && pnl_open;
    wire ovl_commit = ovl_dwr && ovl_half_r;
    wire pnl_commit = pnl_dwr && pnl_half_r;

    // ------------------------------------------------------------
    // Index counters
    // ------------------------------------------------------------
    always_comb
    begin
        ovl_idx_nxt = ovl_idx_r;
        if (wr_go && hit_ovl_idx && lo_en)
            ovl_idx_nxt = avs_writedata_i[7:0];
        else if (ovl_commit)
            ovl_idx_nxt = next_index(ovl_idx_r);
        pnl_idx_nxt = pnl_idx_r;
        if (wr_go && hit_pnl_idx && lo_en)
            pnl_idx_nxt = avs_writedata_i[7:0];
        else if (pnl_commit)
            pnl_idx_nxt = next_index(pnl_idx_r);
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            ovl_idx_r <= GLUT_INDEX_FIRST;
            pnl_idx_r <= GLUT_INDEX_FIRST;
            ovl_data_r <= GLUT_REG_RESET;
            pnl_data_r <= GLUT_REG_RESET;
            ovl_half_r <= 1'b0;
            pnl_half_r <= 1'b0;
            ovl_gr_r <= 8'h00;
            ovl_rd_r <= 8'h00;
            pnl_gr_r <= 8'h00;
            pnl_rd_r <= 8'h00;
            ctrl_r <= GLUT_REG_RESET;
            probe_r <= 8'h00;
        end
        else
        begin
            ovl_idx_r <= ovl_idx_nxt;
            pnl_idx_r <= pnl_idx_nxt;
            if (wr_go && hit_ctrl)
                ctrl_r <= wd16;
            if (wr_go && hit_stat && lo_en)
                probe_r <= avs_writedata_i[7:0];
            if (wr_go && hit_ovl_idx)
                ovl_half_r <= 1'b0;
            else if (ovl_dwr)
            begin
                ovl_data_r <= wd16;
                ovl_half_r <= !ovl_half_r;
                if (!ovl_half_r)
                begin
                    ovl_gr_r <= wd16[15:8];
                    ovl_rd_r <= wd16[7:0];
                end
            end
            if (wr_go && hit_pnl_idx)
                pnl_half_r <= 1'b0;
            else if (pnl_dwr)
            begin
                pnl_data_r <= wd16;
                pnl_half_r <= !pnl_half_r;
                if (!pnl_half_r)
                begin
                    pnl_gr_r <= wd16[15:8];
                    pnl_rd_r <= wd16[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Table memories, entry packed as {blue, green, red}
    // ------------------------------------------------------------
    assign ovl_if.we = ovl_commit;
    assign ovl_if.waddr = ovl_idx_r;
    assign ovl_if.wdata = {wd16[7:0], ovl_gr_r, ovl_rd_r};
    assign ovl_if.raddr = probe_r;
    assign pnl_if.we = pnl_commit;
    assign pnl_if.waddr = pnl_idx_r;
    assign pnl_if.wdata = {wd16[7:0], pnl_gr_r, pnl_rd_r};
    assign pnl_if.raddr = probe_r;

    glut_table_mem #(.DEPTH(GLUT_ENTRIES)) u_ovl_mem (
        .mclk_i(mclk_i),
        .port(ovl_if.mem)
    );

    glut_table_mem #(.DEPTH(GLUT_ENTRIES)) u_pnl_mem (
        .mclk_i(mclk_i),
        .port(pnl_if.mem)
    );

    // ------------------------------------------------------------
    // Bus handshake: two wait cycles per access
    // ------------------------------------------------------------
    wire req = avs_read_i || avs_write_i;
    wire [15:0] rd_mux = hit_ovl_idx ? {8'h00, ovl_idx_r} :
                         hit_ovl_dat ? ovl_data_r :
                         hit_pnl_idx ? {8'h00, pnl_idx_r} :
                         hit_pnl_dat ? pnl_data_r :
                         hit_ctrl ? ctrl_r :
                         hit_stat ? {4'h0, pnl_open, ovl_open, pnl_half_r, ovl_half_r, probe_r} :
                         16'h0000;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            GLUT_IDLE: if (req) state_nxt = GLUT_WAIT;
            GLUT_WAIT: state_nxt = GLUT_DONE;
            GLUT_DONE: state_nxt = GLUT_IDLE;
            default: state_nxt = GLUT_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= GLUT_IDLE;
            rdata_r <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
            ovl_entry_r <= 24'h000000;
            pnl_entry_r <= 24'h000000;
        end
        else
        begin
            state_r <= state_nxt;
            avs_waitrequest_o <= !(state_nxt == GLUT_DONE);
            if (state_r == GLUT_WAIT)
                rdata_r <= {16'h0000, rd_mux};
            ovl_entry_r <= ovl_if.rdata;
            pnl_entry_r <= pnl_if.rdata;
        end
    end

    assign avs_readdata_o = rdata_r;
    assign ovl_entry_o = ovl_entry_r;
    assign pnl_entry_o = pnl_entry_r;
endmodule // glut_loader

/* glut_loader_sva.sv */
// Checker: bus timing and read values of the gamma table loader
`timescale 1ns/1ps
module glut_loader_sva (
    input wire logic mclk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic [glut_pkg::GLUT_AW-1:0] avs_address_i, // Word address
    input wire logic avs_read_i, // Read request
    input wire logic avs_write_i, // Write request
    input wire logic [glut_pkg::GLUT_DW-1:0] avs_writedata_i, // Write data
    input wire logic [3:0] avs_byteenable_i, // Byte enables
    input wire logic [glut_pkg::GLUT_DW-1:0] avs_readdata_o, // Read data
    input wire logic avs_waitrequest_o, // Stall
    input wire logic [23:0] ovl_entry_o, // Overlay entry
    input wire logic [23:0] pnl_entry_o // Panel entry
);
    import glut_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic [11:0] addr_w = {1'b0, avs_address_i};
    wire logic rd_done = avs_read_i && !avs_waitrequest_o;
    wire logic mapped = addr_w inside {GLUT_OVL_INDEX_IDX, GLUT_OVL_DATA_IDX, GLUT_PNL_INDEX_IDX,
        GLUT_PNL_DATA_IDX, GLUT_CTRL_IDX, GLUT_STAT_IDX};
    a_answer_two_edges: assert property ($rose(avs_read_i || avs_write_i) |=> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("Answer not on second edge");
    a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("Waitrequest low too long");
    a_idle_stalls: assert property (!(avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("Waitrequest low while idle");
    a_reset_clean: assert property ($rose(rst_n_i) |-> avs_waitrequest_o && avs_readdata_o == '0 && ovl_entry_o == '0 && pnl_entry_o == '0)
        else $error("Outputs not cleared by reset");
    a_ovl_index_byte: assert property (rd_done && addr_w == GLUT_OVL_INDEX_IDX |-> avs_readdata_o[15:8] == 8'h00)
        else $error("Overlay index upper byte set");
    a_pnl_index_byte: assert property (rd_done && addr_w == GLUT_PNL_INDEX_IDX |-> avs_readdata_o[15:8] == 8'h00)
        else $error("Panel index upper byte set");
    a_upper_half_zero: assert property (rd_done |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("Read data above bit 15 set");
    a_unmapped_zero: assert property (rd_done && !mapped |-> avs_readdata_o == '0)
        else $error("Unmapped read not zero");
endmodule // glut_loader_sva

/* tb_top.sv */
// Testbench: random and corner-case loading of both gamma tables
`timescale 1ns/1ps
module tb_top;
    import glut_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [GLUT_AW-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [GLUT_DW-1:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [GLUT_DW-1:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [23:0] ovl_entry_o;
    logic [23:0] pnl_entry_o;
    logic [23:0] exp_lut [2][256];
    logic [31:0] rdat;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    glut_loader i_glut_loader (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ovl_entry_o(ovl_entry_o), .pnl_entry_o(pnl_entry_o));
    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end
    function automatic logic [11:0] base(input int t);
        return t ? GLUT_PNL_INDEX_IDX : GLUT_OVL_INDEX_IDX;
    endfunction
    function automatic logic [7:0] nxt(input logic [7:0] k, input logic ok);
        return ok ? k + 8'h01 : k;
    endfunction
    task automatic close_out;
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        avs_address_i <= a[GLUT_AW-1:0];
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {16'h0000, d};
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        rdat = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic chk_reg(input logic [11:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        check_count++;
        if (rdat !== {16'h0000, e})
        begin
            fails++;
            $display("FAIL %0t reg %h read %h expected %h", $time, a, rdat, e);
        end
    endtask
    task automatic chk_ent(input int t, input logic [7:0] k, input logic [23:0] e);
        bus(1'b1, GLUT_STAT_IDX, {8'h00, k});
        repeat (3) @(posedge mclk_i);
        check_count++;
        if ((t ? pnl_entry_o : ovl_entry_o) !== e)
        begin
            fails++;
            $display("FAIL %0t table %0d entry %h wrong", $time, t, k);
        end
    endtask
    // Two data port writes per entry, junk in the unused byte of the second
    task automatic put(input int t, input logic [7:0] k, g, r, b, input logic ok);
        bus(1'b1, base(t) + 12'h002, {g, r});
        bus(1'b1, base(t) + 12'h002, {~g, b});
        if (ok)
            exp_lut[t][k] = {b, g, r};
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int seed;
        logic [7:0] g, r, b, k;
        logic [15:0] ctrl_tab [5];
        logic [1:0] ok_tab [5];
        seed = $urandom(85655);
        ctrl_tab = '{16'h0000, 16'h0404, 16'h2004, 16'h2424, 16'h2404};
        ok_tab = '{2'b11, 2'b10, 2'b01, 2'b10, 2'b00};
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int t = 0; t < 2; t++)
        begin
            chk_reg(base(t) + 12'h002, 16'h0000);
            bus(1'b1, base(t), 16'hA5C3);
            chk_reg(base(t), 16'h00C3);
            bus(1'b1, base(t), 16'h0000);
            for (int e = 0; e < 256; e++)
            begin
                {g, r, b} = 24'($urandom);
                put(t, 8'(e), g, r, b, 1'b1);
            end
            chk_reg(base(t), 16'h0000);
            chk_reg(base(t) + 12'h002, {~g, b});
            for (int e = 0; e < 256; e++)
                chk_ent(t, 8'(e), exp_lut[t][e]);
        end
        chk_reg(12'h7FF, 16'h0000);
        for (int m = 0; m < 5; m++)
            for (int t = 0; t < 2; t++)
            begin
                k = (m == 0) ? 8'hFF : 8'($urandom);
                {g, r, b} = 24'($urandom);
                bus(1'b1, GLUT_CTRL_IDX, ctrl_tab[m]);
                bus(1'b1, base(t), {8'h00, k});
                put(t, k, g, r, b, ok_tab[m][t]);
                chk_reg(base(t), {8'h00, nxt(k, ok_tab[m][t])});
                chk_ent(t, k, exp_lut[t][k]);
            end
        bus(1'b1, GLUT_CTRL_IDX, 16'h0000);
        for (int t = 0; t < 2; t++)
        begin
            {g, r, b} = 24'($urandom);
            bus(1'b1, base(t), 16'h005A);
            bus(1'b1, base(t) + 12'h002, {b, r});
            bus(1'b1, base(t), 16'h005A);
            put(t, 8'h5A, g, r, b, 1'b1);
            chk_reg(base(t), 16'h005B);
            chk_ent(t, 8'h5A, exp_lut[t][8'h5A]);
        end
        close_out;
    end
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            close_out;
        end
    end
endmodule // tb_top
bind glut_loader glut_loader_sva i_glut_loader_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ovl_entry_o(ovl_entry_o), .pnl_entry_o(pnl_entry_o));
